// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  import tsr_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic                          mclk_in  = 1'h0;
  logic                          rst_b_in = 1'h0;
  logic                          hsel     = 1'h0;
  logic                          hwrite   = 1'h0;
  logic                          ap       = 1'h1;
  logic [1:0]                    htrans   = 2'h0;
  logic [31:0]                   haddr    = 32'h0;
  logic [31:0]                   hwdata   = 32'h0;
  logic [TSR_AW-1:0]             afi0     = 16'h9000;
  logic [TSR_AW-1:0]             afi1     = 16'h1000;
  logic [TSR_AW-1:0]             pga      = 16'h1000;
  logic [5:0]                    first_cfg = 6'h03;
  logic [5:0]                    len_cfg   = 6'h01;
  tsr_dig_s                      dig      = '0;
  logic [31:0]                   rdq, hrdata;
  logic                          hready, hresp, mux_hold, cfg_err, irq;
  logic [5:0]                    list_first, list_len;
  logic [4:0]                    mux_ch;
  logic [TSR_NUM_DEST-1:0]       seq_trig;
  tsr_route_s                    route;
  logic [TSR_NUM_DEST-1:0][7:0]  cnt, c0;
  int                            err_count = 0;
  int                            checked   = 0;

  always #4 mclk_in = ~mclk_in;

  tsr_trigger i_tsr_trigger (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .dig_in(dig), .analog_present_in(ap), .afi0_in(afi0),
    .afi1_in(afi1), .pga_in(pga), .list_first_ch_in(list_first), .list_len_in(list_len),
    .mux_hold_out(mux_hold), .mux_hold_ch_out(mux_ch), .cfg_err_out(cfg_err),
    .seq_trig_out(seq_trig), .ace_route_out(route), .irq_out(irq));

  tsr_seq_model i_tsr_seq_model (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .seq_trig_in(seq_trig), .first_cfg_in(first_cfg), .len_cfg_in(len_cfg),
    .list_first_ch_out(list_first), .list_len_out(list_len), .trig_cnt_out(cnt));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one single transfer; waits on hready rather than assuming zero wait
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    hsel <= 1'h1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    @(posedge mclk_in);
    while (hready !== 1'h1) @(posedge mclk_in);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
    @(posedge mclk_in);
    while (hready !== 1'h1) @(posedge mclk_in);
    rdq = hrdata;
  endtask : ahb

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc

  function automatic logic [39:0] inc(input logic [39:0] c, input logic [4:0] m);
    inc = c;
    for (int i = 0; i < 5; i++) if (m[i]) inc[i*8 +: 8] = c[i*8 +: 8] + 8'h01;
  endfunction : inc

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    ahb(1'h0, TSR_OFF_CTRL, 32'h0);
    chk("ctrl_reset", rdq, TSR_CTRL_RST);
    chk("route_reset", route, 24'h0);
    ahb(1'h0, TSR_OFF_STAT, 32'h0);
    chk("stat_present", rdq[1:0], 2'h3);
    ahb(1'h1, 8'h40, 32'hffff_ffff);
    ahb(1'h0, 8'h40, 32'h0);
    chk("unmapped", rdq, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // each source kind with both edge choices; exactly one pulse on the selected edge, none on the other
  task automatic t_digital();
    logic [4:0] codes [3] = '{TSR_DSRC_PFL0 + 5'h05, TSR_DSRC_BUS0 + 5'h02, TSR_DSRC_STAR};
    int b;
    for (int s = 0; s < 3; s++) begin
      for (int e = 0; e < 2; e++) begin
        b = (codes[s] <= 5'h10) ? codes[s] + 8 : (codes[s] <= 5'h18) ? codes[s] - 16 : 0;
        ahb(1'h1, TSR_OFF_CTRL, {11'h0, 5'h1f, 10'h0, e[0], codes[s]});
        cyc(6);
        c0 = cnt;
        dig[b] <= 1'h1;
        cyc(8);
        chk("dig_rise", cnt, (e == 0) ? inc(c0, 5'h1f) : c0);
        c0 = cnt;
        dig[b] <= 1'h0;
        cyc(8);
        chk("dig_fall", cnt, (e == 1) ? inc(c0, 5'h1f) : c0);
      end
    end
    $display("test digital done");
  endtask : t_digital

  task automatic t_software();
    logic ia;
    ahb(1'h1, TSR_OFF_CTRL, 32'h001f_0000);
    ahb(1'h1, TSR_OFF_IRQST, 32'h7);
    c0 = cnt;
    ahb(1'h1, TSR_OFF_SWTRIG, 32'h0);
    cyc(4);
    chk("sw_zero", cnt, c0);
    ahb(1'h1, TSR_OFF_SWTRIG, 32'h1);
    cyc(4);
    chk("sw_pulse", cnt, inc(c0, 5'h1f));
    ahb(1'h0, TSR_OFF_IRQST, 32'h0);
    chk("irq_sw_bit", rdq[1], 1'h1);
    ahb(1'h1, TSR_OFF_IRQMSK, 32'h0);
    cyc(1);
    ia = irq;
    ahb(1'h1, TSR_OFF_IRQMSK, 32'h7);
    cyc(1);
    chk("irq_mask", ia ^ irq, 1'h1);
    ahb(1'h1, TSR_OFF_IRQST, 32'h7);
    ahb(1'h0, TSR_OFF_IRQST, 32'h0);
    chk("irq_clear", {rdq[2:0], irq}, 4'h0);
    $display("test software done");
  endtask : t_software

  // below mode on the first input, above mode on the second
  task automatic t_analog();
    ahb(1'h1, TSR_OFF_ALVL, 32'h8000);
    ahb(1'h1, TSR_OFF_ROUTE, 32'h0008_0080);
    for (int m = 0; m < 2; m++) begin
      afi0 <= 16'h9000;
      afi1 <= 16'h1000;
      ahb(1'h1, TSR_OFF_CTRL, 32'h0067_0000 | (m << 12) | (m << 6));
      cyc(4);
      chk("ace_quiet", route, 24'h0);
      c0 = cnt;
      if (m == 0) afi0 <= 16'h1000;
      else afi1 <= 16'h9000;
      cyc(6);
      chk("ace_route", route, {16'h0800, 8'h80});
      chk("ace_dest", cnt, inc(c0, 5'h07));
    end
    afi0 <= 16'h9000;
    $display("test analog done");
  endtask : t_analog

  // channel source: hold the mux and police the channel list
  task automatic t_channel();
    logic [1:0] kd [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
    logic [5:0] fc [5] = '{6'h03, 6'h05, 6'h03, 6'h03, 6'h03};
    logic [5:0] ln [5] = '{6'h04, 6'h04, 6'h01, 6'h02, 6'h02};
    logic       er [5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
    for (int i = 0; i < 5; i++) begin
      first_cfg <= fc[i];
      len_cfg <= ln[i];
      ahb(1'h1, TSR_OFF_CTRL, 32'h0067_0140 | (32'(kd[i]) << 23));
      cyc(4);
      chk("mux_hold", {mux_hold, mux_ch}, {1'h1, 5'h03});
      chk("cfg_err", cfg_err, er[i]);
      chk("pga_event", route, {16'h0800, 8'h80});
    end
    $display("test channel done");
  endtask : t_channel

  // rising hysteresis on channel 3, then window enter and leave, then no variant
  task automatic t_hyst();
    ahb(1'h1, TSR_OFF_AHYS, 32'h1000);
    pga <= 16'h9000;
    ahb(1'h1, TSR_OFF_CTRL, 32'h0067_2140);
    cyc(4);
    chk("hys_unprimed", route, 24'h0);
    pga <= 16'h6000;
    cyc(4);
    chk("hys_low", route, 24'h0);
    pga <= 16'h9000;
    cyc(4);
    chk("hys_set", route, {16'h0800, 8'h80});
    pga <= 16'h7800;
    cyc(4);
    chk("hys_hold", route, {16'h0800, 8'h80});
    pga <= 16'h6000;
    cyc(4);
    chk("hys_drop", route, 24'h0);
    ahb(1'h1, TSR_OFF_CTRL, 32'h0067_4140);
    cyc(4);
    chk("win_enter", route, {16'h0800, 8'h80});
    pga <= 16'h9000;
    cyc(4);
    chk("win_out", route, 24'h0);
    ahb(1'h1, TSR_OFF_CTRL, 32'h0067_c140);
    cyc(4);
    chk("win_leave", route, {16'h0800, 8'h80});
    ap <= 1'h0;
    cyc(4);
    chk("no_analog", route, 24'h0);
    ap <= 1'h1;
    $display("test hysteresis done");
  endtask : t_hyst

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // whole run is a few hundred cycles; this leaves ample margin
  initial begin
    #200us;
    err_count++;
    tally_and_finish();
  end

  initial begin
    cyc(12);
    rst_b_in <= 1'h1;
    t_reset();
    t_digital();
    t_software();
    t_analog();
    t_channel();
    t_hyst();
    tally_and_finish();
  end
endmodule : tb

// [bench/tsr_seq_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// sequencer side stand-in
// ----------------------------------------
module tsr_seq_model
  import tsr_pkg::*;
(
  input  wire logic                    mclk_in,
  input  wire logic                    rst_b_in,
  input  wire logic [TSR_NUM_DEST-1:0] seq_trig_in,
  input  wire logic [5:0]              first_cfg_in,
  input  wire logic [5:0]              len_cfg_in,
  output logic      [5:0]              list_first_ch_out,
  output logic      [5:0]              list_len_out,
  output logic [TSR_NUM_DEST-1:0][7:0] trig_cnt_out
);
  // channel list as the acquisition sequencer publishes it once armed
  assign list_first_ch_out = first_cfg_in;
  assign list_len_out      = len_cfg_in;
  // every sequencer counts action pulses; a held level would count many times
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trig_cnt_out <= '0;
    end else begin
      for (int i = 0; i < TSR_NUM_DEST; i++) begin
        if (seq_trig_in[i]) begin
          trig_cnt_out[i] <= trig_cnt_out[i] + 8'h01;
        end
      end
    end
  end
endmodule : tsr_seq_model

// [hdl/tsr_pkg.sv]
// Behaviour
// - software trigger and external digital trigger always present; analog path optional
// - digital source: any function line, any system trigger bus line, or star line
// - detect rising or falling edge of selected digital source as configured
// - digital trigger deliverable to input, output, counter and waveform sequencers
// - analog source: either analog function input or any analog input channel
// - channel source uses programmable gain amplifier output for detection
// - while waiting on channel trigger, multiplexer holds that channel
// - analog start trigger from channel: channel is first in list
// - reference or pause trigger from channel: list holds exactly one channel
// - comparison event usable by input, output and counter sequencers
// - comparison event routable to any function output or bus line
// - below mode asserts while signal under level; above mode while over
// - rising hysteresis: below low then above high, hold until below low
// - falling hysteresis: above high then below low, hold until above high
// - window mode triggers on entering or leaving the window as configured
package tsr_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] TSR_OFF_CTRL   = 8'h00;
  localparam logic [7:0] TSR_OFF_ALVL   = 8'h04;
  localparam logic [7:0] TSR_OFF_AHYS   = 8'h08;
  localparam logic [7:0] TSR_OFF_ROUTE  = 8'h0c;
  localparam logic [7:0] TSR_OFF_SWTRIG = 8'h10;
  localparam logic [7:0] TSR_OFF_STAT   = 8'h14;
  localparam logic [7:0] TSR_OFF_IRQST  = 8'h18;
  localparam logic [7:0] TSR_OFF_IRQMSK = 8'h1c;
  localparam logic [7:0] TSR_OFF_SEQ    = 8'h20;
  // ctrl field positions
  localparam int TSR_CTRL_DSRC_LSB = 0;   // 5 bits digital source
  localparam int TSR_CTRL_EDGE     = 5;   // 0 rising, 1 falling
  localparam int TSR_CTRL_ASRC_LSB = 6;   // 6 bits analog source
  localparam int TSR_CTRL_AMODE_LSB = 12; // 3 bits analog mode
  localparam int TSR_CTRL_WIN_LEAVE = 15;
  localparam int TSR_CTRL_DEST_LSB = 16;  // 5 bits sequencer enables
  localparam int TSR_CTRL_USE_ANA  = 21;
  localparam int TSR_CTRL_ARM      = 22;
  localparam int TSR_CTRL_KIND_LSB = 23;  // 2 bits trigger kind
  localparam logic [31:0] TSR_CTRL_RST = 32'h0000_0000;
  // digital source codes: 0 none, 1..16 function lines, 17..24 bus, 25 star
  localparam logic [4:0] TSR_DSRC_NONE = 5'h00;
  localparam logic [4:0] TSR_DSRC_PFL0 = 5'h01;
  localparam logic [4:0] TSR_DSRC_BUS0 = 5'h11;
  localparam logic [4:0] TSR_DSRC_STAR = 5'h19;
  // analog source codes: 0,1 function inputs, 2.. input channel (code-2)
  localparam logic [5:0] TSR_ASRC_CH0 = 6'h02;
  localparam int TSR_NUM_PFL = 16;
  localparam int TSR_NUM_BUS = 8;
  localparam int TSR_NUM_CH  = 32;
  localparam int TSR_AW      = 16;
  localparam int TSR_NUM_DEST = 5;
  localparam int TSR_IRQ_W   = 3;
  // sequencer destination bits
  localparam int TSR_DEST_AI = 0;
  localparam int TSR_DEST_AO = 1;
  localparam int TSR_DEST_CTR = 2;
  localparam int TSR_DEST_DI = 3;
  localparam int TSR_DEST_DO = 4;

  typedef enum logic [2:0] {
    TSR_AM_BELOW, TSR_AM_ABOVE, TSR_AM_HYS_RISE, TSR_AM_HYS_FALL, TSR_AM_WINDOW
  } tsr_amode_e;

  typedef enum logic [1:0] {TSR_KIND_START, TSR_KIND_REF, TSR_KIND_PAUSE} tsr_kind_e;

  typedef struct packed {
    logic [TSR_NUM_PFL-1:0] pfl;
    logic [TSR_NUM_BUS-1:0] bus;
    logic                   star;
  } tsr_dig_s;

  typedef struct packed {
    logic [TSR_NUM_PFL-1:0] pfl;
    logic [TSR_NUM_BUS-1:0] bus;
  } tsr_route_s;
endpackage : tsr_pkg

// [hdl/tsr_trigger.sv]
`timescale 1ns/1ps
module tsr_trigger
  import tsr_pkg::*;
(
  input  wire logic                    mclk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    hsel_in,
  input  wire logic [31:0]             haddr_in,
  input  wire logic [1:0]              htrans_in,
  input  wire logic                    hwrite_in,
  input  wire logic [2:0]              hsize_in,
  input  wire logic [31:0]             hwdata_in,
  input  wire logic                    hready_in,
  output logic      [31:0]             hrdata_out,
  output logic                         hreadyout_out,
  output logic                         hresp_out,
  input  wire tsr_dig_s                dig_in,
  input  wire logic                    analog_present_in,
  input  wire logic [TSR_AW-1:0]       afi0_in,
  input  wire logic [TSR_AW-1:0]       afi1_in,
  input  wire logic [TSR_AW-1:0]       pga_in,
  input  wire logic [5:0]              list_first_ch_in,
  input  wire logic [5:0]              list_len_in,
  output logic                         mux_hold_out,
  output logic [4:0]                   mux_hold_ch_out,
  output logic                         cfg_err_out,
  output logic [TSR_NUM_DEST-1:0]      seq_trig_out,
  output tsr_route_s                   ace_route_out,
  output logic                         irq_out
);
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic [31:0] ctrl_reg, lvl_reg, hys_reg, route_reg;
  logic [TSR_IRQ_W-1:0] irqst_reg, irqmsk_reg;
  logic        wr_pend_reg, sw_reg;
  logic [7:0]  waddr_reg;
  wire         take = hsel_in & htrans_in[1] & hready_in;
  wire         wr_ctrl = wr_pend_reg & (waddr_reg == TSR_OFF_CTRL);
  wire         sw_hit  = wr_pend_reg & (waddr_reg == TSR_OFF_SWTRIG) & hwdata_in[0];
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // write capture: address phase then data phase
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pend_reg <= 1'b0;
      waddr_reg   <= 8'h00;
    end else begin
      wr_pend_reg <= take & hwrite_in;
      waddr_reg   <= haddr_in[7:0];
    end
  end

  // config registers, cleared to safe values
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg   <= TSR_CTRL_RST;
      lvl_reg    <= 32'h0;
      hys_reg    <= 32'h0;
      route_reg  <= 32'h0;
      irqmsk_reg <= '0;
      sw_reg     <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_reg <= hwdata_in;
      if (wr_pend_reg && waddr_reg == TSR_OFF_ALVL) lvl_reg <= hwdata_in;
      if (wr_pend_reg && waddr_reg == TSR_OFF_AHYS) hys_reg <= hwdata_in;
      if (wr_pend_reg && waddr_reg == TSR_OFF_ROUTE) route_reg <= hwdata_in;
      if (wr_pend_reg && waddr_reg == TSR_OFF_IRQMSK) irqmsk_reg <= hwdata_in[TSR_IRQ_W-1:0];
      sw_reg <= sw_hit;
    end
  end

  // ----------------------------------------
  // decoded fields
  // ----------------------------------------
  wire [4:0]  dsrc  = ctrl_reg[TSR_CTRL_DSRC_LSB +: 5];
  wire        fall  = ctrl_reg[TSR_CTRL_EDGE];
  wire [5:0]  asrc  = ctrl_reg[TSR_CTRL_ASRC_LSB +: 6];
  wire [2:0]  amode = ctrl_reg[TSR_CTRL_AMODE_LSB +: 3];
  wire        leave = ctrl_reg[TSR_CTRL_WIN_LEAVE];
  wire [4:0]  dest  = ctrl_reg[TSR_CTRL_DEST_LSB +: 5];
  wire        use_a = ctrl_reg[TSR_CTRL_USE_ANA] & analog_present_in;
  wire        arm   = ctrl_reg[TSR_CTRL_ARM];
  wire [1:0]  kind  = ctrl_reg[TSR_CTRL_KIND_LSB +: 2];
  wire        a_is_ch = asrc >= TSR_ASRC_CH0;
  wire [5:0]  a_ch  = asrc - TSR_ASRC_CH0;

  // ----------------------------------------
  // digital source select and edge
  // ----------------------------------------
  logic dsel;
  always_comb begin
    dsel = 1'b0;
    if (dsrc >= TSR_DSRC_PFL0 && dsrc < TSR_DSRC_BUS0)
      dsel = dig_in.pfl[4'(dsrc - TSR_DSRC_PFL0)];
    else if (dsrc >= TSR_DSRC_BUS0 && dsrc < TSR_DSRC_STAR)
      dsel = dig_in.bus[3'(dsrc - TSR_DSRC_BUS0)];
    else if (dsrc == TSR_DSRC_STAR)
      dsel = dig_in.star;
  end

  // two-stage synchroniser, then edge detect comparing the second and third stages
  logic d_s1_reg, d_s2_reg, d_s3_reg;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      d_s1_reg <= 1'b0;
      d_s2_reg <= 1'b0;
      d_s3_reg <= 1'b0;
    end else begin
      d_s1_reg <= dsel;
      d_s2_reg <= d_s1_reg;
      d_s3_reg <= d_s2_reg;
    end
  end
  // source change can fake an edge; software should reselect before arming
  wire dig_edge = (dsrc != TSR_DSRC_NONE) &
                  (fall ? (d_s3_reg & ~d_s2_reg) : (~d_s3_reg & d_s2_reg));

  // ----------------------------------------
  // analog comparison
  // ----------------------------------------
  logic [TSR_AW-1:0] asig;
  always_comb begin
    unique case (asrc)
      6'h00:   asig = afi0_in;
      6'h01:   asig = afi1_in;
      default: asig = pga_in;
    endcase
  end
  wire [TSR_AW-1:0] lvl = lvl_reg[TSR_AW-1:0];  // level, or window top
  wire [TSR_AW-1:0] hys = hys_reg[TSR_AW-1:0];  // hysteresis, or window bottom
  wire [TSR_AW:0]   hi_f = {1'b0, lvl} + {1'b0, hys};
  wire [TSR_AW:0]   lo_r = {1'b0, lvl} - {1'b0, hys};
  wire below = asig < lvl;
  wire above = asig > lvl;
  wire r_low  = lo_r[TSR_AW] ? 1'b0 : (asig < lo_r[TSR_AW-1:0]);
  wire f_high = {1'b0, asig} > hi_f;
  wire in_win = (asig < lvl) & (asig > hys);

  logic hys_reg_st, ace_reg, inwin_reg, prime_reg;
  logic ace_next, hys_next, prime_next;
  // prime records the first crossing of the far threshold; without it a
  // signal that starts past the near threshold would raise a false event
  always_comb begin
    hys_next   = hys_reg_st;
    prime_next = prime_reg;
    ace_next   = 1'b0;
    unique case (amode)
      TSR_AM_BELOW: ace_next = below;
      TSR_AM_ABOVE: ace_next = above;
      TSR_AM_HYS_RISE: begin
        if (r_low) begin
          hys_next   = 1'b0;
          prime_next = 1'b1;
        end else if (above && prime_reg) begin
          hys_next = 1'b1;
        end
        ace_next = hys_next;
      end
      TSR_AM_HYS_FALL: begin
        if (f_high) begin
          hys_next   = 1'b0;
          prime_next = 1'b1;
        end else if (below && prime_reg) begin
          hys_next = 1'b1;
        end
        ace_next = hys_next;
      end
      TSR_AM_WINDOW: ace_next = leave ? ~in_win : in_win;
      default: ace_next = 1'b0;
    endcase
  end
  // hysteresis latch starts disarmed so a signal already past the
  // threshold must first cross back before the event is raised
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hys_reg_st <= 1'b0;
      ace_reg    <= 1'b0;
      inwin_reg  <= 1'b0;
      prime_reg  <= 1'b0;
    end else begin
      prime_reg  <= use_a & prime_next;
      hys_reg_st <= use_a & hys_next;
      ace_reg    <= use_a & ace_next;
      inwin_reg  <= ace_reg;
    end
  end
  wire ace_rise = ace_reg & ~inwin_reg;

  // ----------------------------------------
  // delivery to sequencers and routing
  // ----------------------------------------
  wire trig = use_a ? ace_rise : dig_edge;
  logic [TSR_NUM_DEST-1:0] seq_reg;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) seq_reg <= '0;
    else if (use_a)
      seq_reg <= {2'b00, {3{ace_rise | sw_reg}} & dest[2:0]};
    else
      seq_reg <= {TSR_NUM_DEST{dig_edge | sw_reg}} & dest;
  end
  assign seq_trig_out = seq_reg;
  assign ace_route_out = route_reg[TSR_NUM_PFL+TSR_NUM_BUS-1:0] &
                         {(TSR_NUM_PFL+TSR_NUM_BUS){ace_reg}};

  // mux hold while armed on an input channel
  assign mux_hold_out    = arm & use_a & a_is_ch;
  assign mux_hold_ch_out = a_ch[4:0];
  wire err_start = (kind == TSR_KIND_START) & (list_first_ch_in != a_ch);
  wire err_one   = (kind != TSR_KIND_START) & (list_len_in != 6'h01);
  assign cfg_err_out = mux_hold_out & (err_start | err_one);

  // ----------------------------------------
  // interrupts: trig, sw, config error
  // ----------------------------------------
  wire [TSR_IRQ_W-1:0] ev  = {cfg_err_out, sw_reg, trig};
  wire [TSR_IRQ_W-1:0] clr = (wr_pend_reg && waddr_reg == TSR_OFF_IRQST) ?
                             hwdata_in[TSR_IRQ_W-1:0] : '0;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) irqst_reg <= '0;
    else irqst_reg <= (irqst_reg & ~clr) | ev; // set wins
  end
  assign irq_out = |(irqst_reg & irqmsk_reg);

  // ----------------------------------------
  // read mux, address registered for the data phase
  // ----------------------------------------
  logic [7:0] rsel;
  wire [31:0] stat = {25'h0, cfg_err_out, mux_hold_out, ace_reg, use_a, d_s2_reg,
                      analog_present_in, 1'b1};
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) rsel <= 8'hff;
    else if (take && !hwrite_in) rsel <= haddr_in[7:0];
  end
  always_comb begin
    unique case (rsel)
      TSR_OFF_CTRL:   hrdata_out = ctrl_reg;
      TSR_OFF_ALVL:   hrdata_out = lvl_reg;
      TSR_OFF_AHYS:   hrdata_out = hys_reg;
      TSR_OFF_ROUTE:  hrdata_out = route_reg;
      TSR_OFF_STAT:   hrdata_out = stat;
      TSR_OFF_IRQST:  hrdata_out = {29'h0, irqst_reg};
      TSR_OFF_IRQMSK: hrdata_out = {29'h0, irqmsk_reg};
      default:        hrdata_out = 32'h0;
    endcase
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_rise_pulse;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (!use_a && !fall && dsrc != TSR_DSRC_NONE && d_s2_reg && !d_s3_reg && dest[0])
      |=> seq_trig_out[0];
  endproperty
  a_rise_pulse: assert property (p_rise_pulse) else $error("rising edge missed");
  property p_one_cycle;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (seq_trig_out[0] && !sw_reg && !use_a) |=> !seq_trig_out[0] || sw_reg;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("pulse too long");
  property p_noroute;
    @(posedge mclk_in) disable iff (!rst_b_in) (route_reg == 32'h0) |-> ace_route_out == '0;
  endproperty
  a_noroute: assert property (p_noroute) else $error("event driven unrouted");
  property p_hold;
    @(posedge mclk_in) disable iff (!rst_b_in)
      mux_hold_out |-> mux_hold_ch_out == a_ch[4:0] && a_is_ch;
  endproperty
  a_hold: assert property (p_hold) else $error("mux hold wrong");
  property p_below;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (use_a && amode == TSR_AM_BELOW && below) |=> ace_reg || $past(ctrl_reg) != ctrl_reg;
  endproperty
  a_below: assert property (p_below) else $error("below mode");
  property p_dwave_ana;
    @(posedge mclk_in) disable iff (!rst_b_in) $past(use_a) |-> seq_trig_out[4:3] == 2'b00;
  endproperty
  a_dwave_ana: assert property (p_dwave_ana) else $error("analog to waveform");
  property p_route;
    @(posedge mclk_in) disable iff (!rst_b_in) ace_reg |-> ace_route_out == route_reg[23:0];
  endproperty
  a_route: assert property (p_route) else $error("route mismatch");
  property p_irq;
    @(posedge mclk_in) disable iff (!rst_b_in) trig |=> irqst_reg[0];
  endproperty
  a_irq: assert property (p_irq) else $error("event lost");
  property p_hys_arm;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (amode == TSR_AM_HYS_RISE && !prime_reg && !r_low) |=> !hys_reg_st;
  endproperty
  a_hys_arm: assert property (p_hys_arm) else $error("hysteresis not primed");
  c_hys: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    hys_reg_st && amode == TSR_AM_HYS_RISE);
  c_dig: cover property (@(posedge mclk_in) disable iff (!rst_b_in) dig_edge);
  c_ace: cover property (@(posedge mclk_in) disable iff (!rst_b_in) ace_rise);
  c_sw:  cover property (@(posedge mclk_in) disable iff (!rst_b_in) sw_reg);
endmodule : tsr_trigger
